/* rtl/bcu_core.sv */
/*
 * bit clear / field extract / field insert execution unit with its own
 * sixteen working registers and a read-modify-write data memory port.
 * assumes a data memory with combinational read on mem_raddr_o and a
 * registered write port; the fetch stage offers one instruction word per cycle.
 */
// Function
// RULE1 - opcode a9 clears one bit in file register
// RULE2 - software keeps file addresses in legal range
// RULE3 - bits numbered from lsb zero upward
// RULE4 - software keeps byte positions within zero..seven
// RULE5 - clear position includes separate top encoding bit
// RULE6 - width select zero word, one byte
// RULE7 - direct or five indirect addressing modes
// RULE8 - indirect accesses carry data read page
// RULE9 - single bit clears finish in one cycle
// RULE10 - register extract copies field to bit zero
// RULE11 - extract zeroes destination bits above field
// RULE12 - memory extract reads word address second word
// RULE13 - low and high edges from codes
// RULE14 - extract destination w, source s, mode p
// RULE15 - insert overwrites field bits in place
// RULE16 - insert ignores source bits above width
// RULE17 - insert destination d, direct or indirect
// RULE18 - no flags touched; field ops two words
// RULE19 - pointer steps two for word, one byte
`include "bcu_map.svh"
module bcu_core
   import bcu_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic insn_valid_i,
   input wire logic [23:0] insn_i,
   output logic insn_ready_o,
   output logic done_o,
   output logic illegal_o,
   input wire logic page_en_i,
   input wire logic [9:0] data_read_page_reg_i,
   output logic [15:0] mem_raddr_o,
   output logic mem_page_en_o,
   output logic [9:0] mem_page_o,
   input wire logic [15:0] mem_rdata_i,
   output logic mem_we_o,
   output logic [15:0] mem_waddr_o,
   output logic [1:0] mem_be_o,
   output logic [15:0] mem_wdata_o,
   input wire logic wreg_we_i,
   input wire logic [3:0] wreg_waddr_i,
   input wire logic [15:0] wreg_wdata_i,
   input wire logic [3:0] wreg_raddr_i,
   output logic [15:0] wreg_rdata_o
);
   // ------------------------
   // state
   // ------------------------
   bcu_state_t state;
   bcu_fop_t fop;
   logic [23:0] word1;
   logic [15:0] wreg [16];

   // ------------------------
   // decode
   // ------------------------
   logic [7:0] op8;
   logic [11:0] op12;
   logic in_first;
   logic in_second;
   logic clr_f;
   logic clr_w;
   logic start_field;
   logic byte_mode;
   logic [3:0] clr_pos;
   logic [3:0] idx;
   logic [15:0] ptr;

   assign op8 = insn_i[`BCU_OP8_HI:`BCU_OP8_LO];
   assign op12 = insn_i[`BCU_OP8_HI:`BCU_OP12_LO];
   assign in_first = insn_valid_i && (state == BCU_ST_FIRST);
   assign in_second = insn_valid_i && (state == BCU_ST_SECOND);
   assign clr_f = in_first && (op8 == `BCU_OP_CLR_FILE); // RULE1
   assign clr_w = in_first && (op8 == `BCU_OP_CLR_WREG);
   assign start_field = in_first && ((op12 == `BCU_OP_EXT_WREG) ||
      (op12 == `BCU_OP_EXT_FILE) || (op12 == `BCU_OP_INS_WREG));
   // width select only exists in the register clear form
   assign byte_mode = clr_w && (insn_i[`BCU_WIDTH_SEL] != `BCU_WORD_SEL); // RULE6
   assign clr_pos = clr_f ? {insn_i[`BCU_CLRF_POS_TOP],
      insn_i[`BCU_CLRF_POS_HI:`BCU_CLRF_POS_LO]} : // RULE5
      insn_i[`BCU_CLRW_POS_HI:`BCU_CLRW_POS_LO];
   assign idx = insn_i[`BCU_REG_HI:`BCU_REG_LO]; // RULE14 RULE17
   assign ptr = wreg[idx];
   assign insn_ready_o = 1'b1;

   // ------------------------
   // address generation and field datapath
   // ------------------------
   logic indirect;
   logic [15:0] ea;
   logic ptr_we;
   logic [15:0] ptr_next;
   logic [15:0] fmask;
   logic [15:0] fext;
   logic [15:0] fins;
   logic [15:0] fsrc;
   logic [15:0] fdst;

   bcu_agu u_agu (
      .mode_i(insn_i[`BCU_MODE_HI:`BCU_MODE_LO]),
      .ptr_i(ptr),
      .byte_mode_i(byte_mode),
      .indirect_o(indirect),
      .ea_o(ea),
      .ptr_we_o(ptr_we),
      .ptr_next_o(ptr_next)
   );

   bcu_field u_field (
      .low_edge_code_i(word1[`BCU_LOW_HI:`BCU_LOW_LO]),
      .high_edge_code_i(word1[`BCU_HIGH_HI:`BCU_HIGH_LO]),
      .src_i(fsrc),
      .dst_i(fdst),
      .mask_o(fmask),
      .extract_o(fext),
      .insert_o(fins)
   );

   // bit 0 is the lsb, bit 15 the msb of a word
   function automatic logic [15:0] clear_mask(input logic [3:0] pos);
      return ~(16'h0001 << pos); // RULE3
   endfunction

   // ------------------------
   // execute
   // ------------------------
   logic [15:0] raddr;
   logic use_mem;
   logic next_rf_we;
   logic [3:0] next_rf_wa;
   logic [15:0] next_rf_wd;
   logic next_ptr_we;
   logic next_mem_we;
   logic [15:0] next_mem_waddr;
   logic [1:0] next_mem_be;
   logic [15:0] next_mem_wdata;
   logic [3:0] lane_pos;

   always_comb begin
      raddr = {ea[15:1], 1'b0};
      use_mem = 1'b0;
      fsrc = wreg[word1[`BCU_DST_HI:`BCU_DST_LO]];
      fdst = wreg[idx];
      next_rf_we = 1'b0;
      next_rf_wa = idx;
      next_rf_wd = `BCU_RESET_WORD;
      next_ptr_we = 1'b0;
      next_mem_we = 1'b0;
      next_mem_waddr = raddr;
      next_mem_be = 2'b11;
      next_mem_wdata = mem_rdata_i;
      lane_pos = {ea[0], clr_pos[2:0]};
      if (clr_f) begin
         raddr = {3'h0, insn_i[`BCU_CLRF_ADR_HI:`BCU_CLRF_ADR_LO], 1'b0}; // RULE1
         next_mem_we = 1'b1;
         next_mem_waddr = raddr;
         next_mem_wdata = mem_rdata_i & clear_mask(clr_pos); // RULE1
      end else if (clr_w && !indirect) begin
         next_rf_we = 1'b1;
         // byte form clears only within the low byte of the register
         next_rf_wd = ptr & clear_mask(byte_mode ? {1'b0, clr_pos[2:0]} : clr_pos); // RULE6
      end else if (clr_w) begin
         use_mem = 1'b1;
         next_ptr_we = ptr_we;
         next_mem_we = 1'b1;
         next_mem_be = byte_mode ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
         next_mem_wdata = mem_rdata_i & clear_mask(byte_mode ? lane_pos : clr_pos); // RULE7
      end else if (in_second && (fop == BCU_FOP_EXTF)) begin
         raddr = {insn_i[`BCU_FADR_HI:`BCU_FADR_LO], 1'b0}; // RULE12
         // direct-address reads never take the read page
         fsrc = mem_rdata_i;
         next_rf_we = 1'b1;
         next_rf_wa = word1[`BCU_DST_HI:`BCU_DST_LO];
         next_rf_wd = fext; // RULE12
      end else if (in_second && (fop == BCU_FOP_EXTW)) begin
         use_mem = indirect;
         fsrc = indirect ? mem_rdata_i : ptr; // RULE14
         next_ptr_we = ptr_we;
         next_rf_we = 1'b1;
         next_rf_wa = word1[`BCU_DST_HI:`BCU_DST_LO];
         next_rf_wd = fext; // RULE10 RULE11
      end else if (in_second && (fop == BCU_FOP_INSW)) begin
         next_ptr_we = ptr_we;
         if (indirect) begin
            use_mem = 1'b1;
            fdst = mem_rdata_i;
            next_mem_we = 1'b1;
            next_mem_wdata = fins; // RULE17
         end else begin
            next_rf_we = 1'b1;
            next_rf_wd = fins; // RULE15
         end
      end
   end

   assign mem_raddr_o = raddr;
   assign mem_page_en_o = use_mem && indirect && page_en_i; // RULE8
   assign mem_page_o = data_read_page_reg_i;

   // ------------------------
   // sequencing
   // ------------------------
   // status flags are not an output at all: nothing here can alter them
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state <= BCU_ST_FIRST;
         fop <= BCU_FOP_NONE;
         word1 <= 24'h000000;
      end else begin
         case (state)
            BCU_ST_FIRST: begin
               if (start_field) begin
                  state <= BCU_ST_SECOND; // RULE18
                  word1 <= insn_i;
                  fop <= (op12 == `BCU_OP_EXT_WREG) ? BCU_FOP_EXTW :
                     (op12 == `BCU_OP_EXT_FILE) ? BCU_FOP_EXTF : BCU_FOP_INSW;
               end
            end
            BCU_ST_SECOND: begin
               if (insn_valid_i) begin
                  state <= BCU_ST_FIRST;
                  fop <= BCU_FOP_NONE;
               end
            end
            default: begin
               state <= BCU_ST_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         done_o <= clr_f || clr_w || in_second; // RULE9 RULE18
         illegal_o <= in_first && !clr_f && !clr_w && !start_field;
      end
   end

   // ------------------------
   // memory write port
   // ------------------------
   // write lands one cycle after the read, so back-to-back hits need forwarding
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mem_we_o <= 1'b0;
         mem_waddr_o <= `BCU_RESET_WORD;
         mem_be_o <= 2'b00;
         mem_wdata_o <= `BCU_RESET_WORD;
      end else begin
         mem_we_o <= next_mem_we;
         mem_waddr_o <= next_mem_waddr;
         mem_be_o <= next_mem_we ? next_mem_be : 2'b00;
         mem_wdata_o <= next_mem_wdata;
      end
   end

   // ------------------------
   // working registers
   // ------------------------
   // the unit's own result wins over the outside write port
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            wreg[i] <= `BCU_RESET_WORD;
         end
      end else begin
         if (wreg_we_i) begin
            wreg[wreg_waddr_i] <= wreg_wdata_i;
         end
         if (next_ptr_we) begin
            wreg[idx] <= ptr_next; // RULE19
         end
         if (next_rf_we) begin
            wreg[next_rf_wa] <= next_rf_wd;
         end
      end
   end

   assign wreg_rdata_o = wreg[wreg_raddr_i];

   // ------------------------
   // checks
   // ------------------------
   sequence s_field_first;
      start_field;
   endsequence

   sequence s_field_second;
      in_second;
   endsequence

   chk_clear_file_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE1
      clr_f |=> mem_we_o && (mem_wdata_o == ($past(mem_rdata_i) & clear_mask($past(clr_pos)))))
      else $error("file clear wrote wrong data");

   chk_clear_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE9
      (clr_f || clr_w) |=> done_o && (state == BCU_ST_FIRST))
      else $error("bit clear did not finish in one cycle");

   chk_field_two_words: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE18
      s_field_first ##1 s_field_second |=> done_o && (state == BCU_ST_FIRST))
      else $error("field op did not finish after second word");

   chk_field_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE18
      s_field_first |=> (state == BCU_ST_SECOND) && !done_o)
      else $error("field op did not wait for second word");

   chk_extract_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE11
      (in_second && (fop != BCU_FOP_INSW)) |=>
      ((wreg[$past(next_rf_wa)] & ~($past(fmask) >> $past(word1[3:0]))) == 16'h0000))
      else $error("extract left bits above the field");

   chk_insert_keeps_rest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE15
      (in_second && (fop == BCU_FOP_INSW) && !indirect && !wreg_we_i) |=>
      ((wreg[$past(idx)] & ~$past(fmask)) == ($past(ptr) & ~$past(fmask))))
      else $error("insert disturbed bits outside the field");

   chk_ptr_word_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE19
      (next_ptr_we && !byte_mode && !wreg_we_i && !(next_rf_we && next_rf_wa == idx) &&
      (insn_i[6:4] == `BCU_AM_POSTINC)) |=> (wreg[$past(idx)] == $past(ptr) + 16'h0002))
      else $error("word post-increment did not step by two");

   chk_page_use: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE8
      (clr_w && indirect && page_en_i) |-> mem_page_en_o && (mem_page_o == data_read_page_reg_i))
      else $error("indirect clear did not carry the read page");

   chk_byte_lane: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE6
      (clr_w && byte_mode && indirect) |=> mem_we_o && $onehot(mem_be_o))
      else $error("byte clear wrote more than one lane");
endmodule

/* inc/bcu_map.svh */
/*
 * constants of the bit clear / field unit: opcodes, field positions, encodings.
 * assumes 24-bit instruction words delivered one per cycle by the fetch stage.
 */
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH

// ------------------------
// opcode values and positions
// ------------------------
`define BCU_OP8_HI 23
`define BCU_OP8_LO 16
`define BCU_OP12_LO 12
`define BCU_OP_CLR_FILE 8'ha9
`define BCU_OP_CLR_WREG 8'ha1
`define BCU_OP_EXT_WREG 12'h0a8
`define BCU_OP_EXT_FILE 12'h0aa
`define BCU_OP_INS_WREG 12'h0a0

// ------------------------
// operand fields
// ------------------------
`define BCU_REG_HI 3
`define BCU_REG_LO 0
`define BCU_MODE_HI 6
`define BCU_MODE_LO 4
`define BCU_WIDTH_SEL 10
`define BCU_CLRW_POS_HI 15
`define BCU_CLRW_POS_LO 12
`define BCU_CLRF_POS_HI 15
`define BCU_CLRF_POS_LO 13
`define BCU_CLRF_POS_TOP 0
`define BCU_CLRF_ADR_HI 12
`define BCU_CLRF_ADR_LO 1
`define BCU_DST_HI 11
`define BCU_DST_LO 8
`define BCU_HIGH_HI 7
`define BCU_HIGH_LO 4
`define BCU_LOW_HI 3
`define BCU_LOW_LO 0
`define BCU_FADR_HI 15
`define BCU_FADR_LO 1

// ------------------------
// addressing modes and pointer steps
// ------------------------
`define BCU_AM_DIRECT 3'h0
`define BCU_AM_IND 3'h1
`define BCU_AM_POSTDEC 3'h2
`define BCU_AM_POSTINC 3'h3
`define BCU_AM_PREDEC 3'h4
`define BCU_AM_PREINC 3'h5
`define BCU_STEP_WORD 16'h0002
`define BCU_STEP_BYTE 16'h0001
`define BCU_WORD_SEL 1'b0
`define BCU_RESET_WORD 16'h0000

`endif

/* inc/bcu_pkg.sv */
/*
 * types of the bit clear / field unit.
 * assumes bcu_map.svh for the numeric constants.
 */
package bcu_pkg;
   typedef enum logic [1:0] {
      BCU_ST_FIRST  = 2'h1,
      BCU_ST_SECOND = 2'h2
   } bcu_state_t;

   typedef enum logic [2:0] {
      BCU_FOP_NONE = 3'h0,
      BCU_FOP_EXTW = 3'h1,
      BCU_FOP_EXTF = 3'h2,
      BCU_FOP_INSW = 3'h4
   } bcu_fop_t;
endpackage

/* rtl/bcu_field.sv */
/*
 * field mask, extract and insert datapath, purely combinational.
 * assumes low and high edge codes straight from the instruction word.
 */
module bcu_field
   import bcu_pkg::*;
(
   input wire logic [3:0] low_edge_code_i,
   input wire logic [3:0] high_edge_code_i,
   input wire logic [15:0] src_i,
   input wire logic [15:0] dst_i,
   output logic [15:0] mask_o,
   output logic [15:0] extract_o,
   output logic [15:0] insert_o
);
   // ------------------------
   // span mask
   // ------------------------
   // a high edge below the low edge gives an empty field, never a wrap
   function automatic logic [15:0] span_mask(input logic [3:0] lo, input logic [3:0] hi);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         m[i] = (4'(i) >= lo) && (4'(i) <= hi);
      end
      return m;
   endfunction

   // ------------------------
   // datapath
   // ------------------------
   assign mask_o = span_mask(low_edge_code_i, high_edge_code_i); // RULE13
   assign extract_o = (src_i & mask_o) >> low_edge_code_i; // RULE10 RULE11
   assign insert_o = (dst_i & ~mask_o) | ((src_i << low_edge_code_i) & mask_o); // RULE15 RULE16
endmodule

/* rtl/bcu_agu.sv */
/*
 * indirect address generator: effective address and pointer update.
 * assumes the pointer value is read from the working registers this cycle.
 */
`include "bcu_map.svh"
module bcu_agu
   import bcu_pkg::*;
(
   input wire logic [2:0] mode_i,
   input wire logic [15:0] ptr_i,
   input wire logic byte_mode_i,
   output logic indirect_o,
   output logic [15:0] ea_o,
   output logic ptr_we_o,
   output logic [15:0] ptr_next_o
);
   // ------------------------
   // step size
   // ------------------------
   function automatic logic [15:0] step(input logic byte_mode);
      return byte_mode ? `BCU_STEP_BYTE : `BCU_STEP_WORD; // RULE19
   endfunction

   // ------------------------
   // mode decode
   // ------------------------
   always_comb begin
      indirect_o = 1'b1;
      ea_o = ptr_i;
      ptr_we_o = 1'b0;
      ptr_next_o = ptr_i;
      case (mode_i) // RULE7
         `BCU_AM_DIRECT: begin
            indirect_o = 1'b0;
         end
         `BCU_AM_IND: begin
            ea_o = ptr_i;
         end
         `BCU_AM_POSTDEC: begin
            ptr_we_o = 1'b1;
            ptr_next_o = ptr_i - step(byte_mode_i); // RULE19
         end
         `BCU_AM_POSTINC: begin
            ptr_we_o = 1'b1;
            ptr_next_o = ptr_i + step(byte_mode_i); // RULE19
         end
         `BCU_AM_PREDEC: begin
            ptr_we_o = 1'b1;
            ptr_next_o = ptr_i - step(byte_mode_i);
            ea_o = ptr_next_o;
         end
         `BCU_AM_PREINC: begin
            ptr_we_o = 1'b1;
            ptr_next_o = ptr_i + step(byte_mode_i);
            ea_o = ptr_next_o;
         end
         default: begin
            ea_o = ptr_i;
         end
      endcase
   end
endmodule

/* test/test_bit_clear_field_unit.sv */
/*
 * self-checking bench of the bit clear / field unit core: clears, extracts,
 * inserts, refused words and a reset in mid-instruction.
 * assumes bcu_core with a combinational-read data memory modelled here and
 * instruction words offered one per cycle by this bench.
 */
`include "bcu_map.svh"
`define CHK(n, e, g) check(n, 16'(e), 16'(g))

module test_bit_clear_field_unit
   import bcu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------
   // signals and data memory model
   // ------------------------
   logic clk_sys_i, rst_n_i, insn_valid_i, page_en_i, wreg_we_i;
   logic insn_ready_o, done_o, illegal_o, mem_page_en_o, mem_we_o;
   logic [23:0] insn_i;
   logic [9:0] data_read_page_reg_i, mem_page_o;
   logic [15:0] mem_rdata_i, wreg_wdata_i, mem_raddr_o, mem_waddr_o, mem_wdata_o;
   logic [15:0] wreg_rdata_o;
   logic [3:0] wreg_waddr_i, wreg_raddr_i;
   logic [1:0] mem_be_o;
   logic [15:0] mem [0:32767];
   int mismatches, compares, cycles;

   bcu_core uut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .insn_valid_i(insn_valid_i),
      .insn_i(insn_i), .insn_ready_o(insn_ready_o), .done_o(done_o),
      .illegal_o(illegal_o), .page_en_i(page_en_i),
      .data_read_page_reg_i(data_read_page_reg_i), .mem_raddr_o(mem_raddr_o),
      .mem_page_en_o(mem_page_en_o), .mem_page_o(mem_page_o),
      .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
      .mem_be_o(mem_be_o), .mem_wdata_o(mem_wdata_o), .wreg_we_i(wreg_we_i),
      .wreg_waddr_i(wreg_waddr_i), .wreg_wdata_i(wreg_wdata_i),
      .wreg_raddr_i(wreg_raddr_i), .wreg_rdata_o(wreg_rdata_o)
   );

   // read is combinational, as the core expects; write lands one edge later
   assign mem_rdata_i = mem[mem_raddr_o[15:1]];
   always @(posedge clk_sys_i) begin
      if (mem_we_o === 1'b1) begin
         if (mem_be_o[0]) mem[mem_waddr_o[15:1]][7:0] <= mem_wdata_o[7:0];
         if (mem_be_o[1]) mem[mem_waddr_o[15:1]][15:8] <= mem_wdata_o[15:8];
      end
   end

   // ------------------------
   // helpers
   // ------------------------
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic logic [23:0] clrf(input logic [3:0] pos, input logic [15:0] adr);
      return {`BCU_OP_CLR_FILE, pos[2:0], adr[12:1], pos[3]};
   endfunction

   function automatic logic [23:0] clrw(input logic [3:0] pos, input logic bsel,
         input logic [2:0] mode, input logic [3:0] r);
      return {`BCU_OP_CLR_WREG, pos, 1'b0, bsel, 2'b00, 1'b0, mode, r};
   endfunction

   function automatic logic [23:0] fw1(input logic [11:0] op, input logic [3:0] w,
         input logic [3:0] hi, input logic [3:0] lo);
      return {op, w, hi, lo};
   endfunction

   function automatic logic [23:0] fw2(input logic [2:0] mode, input logic [3:0] r);
      return {17'h00000, mode, r};
   endfunction

   task automatic send(input logic [23:0] w);
      @(posedge clk_sys_i);
      insn_valid_i <= 1'b1;
      insn_i <= w;
   endtask

   task automatic idle();
      @(posedge clk_sys_i);
      insn_valid_i <= 1'b0;
   endtask

   task automatic wset(input logic [3:0] i, input logic [15:0] v);
      @(posedge clk_sys_i);
      wreg_we_i <= 1'b1;
      wreg_waddr_i <= i;
      wreg_wdata_i <= v;
      @(posedge clk_sys_i);
      wreg_we_i <= 1'b0;
   endtask

   task automatic wget(input logic [3:0] i, output logic [15:0] v);
      @(posedge clk_sys_i);
      wreg_raddr_i <= i;
      #1;
      v = wreg_rdata_o;
   endtask

   // ------------------------
   // scenarios
   // ------------------------
   task automatic t_reset();
      logic [15:0] v;
      #1;
      `CHK("done_o", 1'b0, done_o);
      `CHK("illegal_o", 1'b0, illegal_o);
      `CHK("mem_be_o", 2'b00, mem_be_o);
      `CHK("insn_ready_o", 1'b1, insn_ready_o);
      for (int i = 0; i < 16; i++) begin
         wget(4'(i), v);
         `CHK("wreg after reset", 16'h0000, v);
      end
      $display("test reset values done");
   endtask

   // sixteen back-to-back clears, one per cycle, then the top file address
   task automatic t_clr_file();
      for (int p = 0; p < 16; p++) mem[15'h0400 + 15'(p)] = 16'hffff;
      mem[15'h0fff] = 16'h8aa5;
      for (int p = 0; p < 17; p++) begin
         send(p < 16 ? clrf(4'(p), 16'h0800 + 16'(2 * p)) : clrf(4'hf, 16'h1ffe));
         #1;
         `CHK("mem_raddr_o", p < 16 ? 16'h0800 + 16'(2 * p) : 16'h1ffe, mem_raddr_o);
         if (p > 0) begin
            `CHK("done_o", 1'b1, done_o);
            `CHK("mem_be_o", 2'b11, mem_be_o);
         end
      end
      idle();
      @(posedge clk_sys_i);
      #1;
      for (int p = 0; p < 16; p++) begin
         `CHK("cleared word", ~(16'h0001 << p), mem[15'h0400 + 15'(p)]);
      end
      `CHK("top address", 16'h0aa5, mem[15'h0fff]);
      $display("test file clear done");
   endtask

   task automatic t_clr_wreg();
      logic [15:0] v, ea, step;
      wset(4'h3, 16'hffff);
      wset(4'h4, 16'hffff);
      send(clrw(4'hf, 1'b0, `BCU_AM_DIRECT, 4'h3));
      send(clrw(4'h7, 1'b1, `BCU_AM_DIRECT, 4'h4));
      idle();
      wget(4'h3, v);
      `CHK("word clear", 16'h7fff, v);
      wget(4'h4, v);
      `CHK("byte clear", 16'hff7f, v);
      for (int b = 0; b < 2; b++) begin
         for (int m = 1; m < 6; m++) begin
            step = b ? 16'h0001 : 16'h0002;
            mem[15'h007f] = 16'hffff;
            mem[15'h0080] = 16'hffff;
            mem[15'h0081] = 16'hffff;
            wset(4'h5, 16'h0100);
            ea = (m == 4) ? 16'h0100 - step : (m == 5) ? 16'h0100 + step : 16'h0100;
            page_en_i <= (b == 0);
            send(clrw(b ? 4'h3 : 4'hb, b[0], 3'(m), 4'h5));
            #1;
            `CHK("mem_raddr_o", {ea[15:1], 1'b0}, mem_raddr_o);
            `CHK("mem_page_en_o", b == 0, mem_page_en_o);
            `CHK("mem_page_o", data_read_page_reg_i, mem_page_o);
            idle();
            @(posedge clk_sys_i);
            #1;
            `CHK("indirect clear", ~(16'h0001 << ((b && !ea[0]) ? 3 : 11)),
               mem[ea[15:1]]);
            wget(4'h5, v);
            `CHK("pointer", (m == 2 || m == 4) ? 16'h0100 - step :
               (m == 1) ? 16'h0100 : 16'h0100 + step, v);
         end
      end
      page_en_i <= 1'b1;
      $display("test register clear done");
   endtask

   task automatic t_extract();
      logic [15:0] v;
      int lo[4] = '{4, 0, 15, 9};
      int hi[4] = '{11, 15, 15, 9};
      wset(4'h2, 16'hb5c3);
      for (int i = 0; i < 4; i++) begin
         wset(4'h7, 16'hffff);
         send(fw1(`BCU_OP_EXT_WREG, 4'h7, 4'(hi[i]), 4'(lo[i])));
         send(fw2(`BCU_AM_DIRECT, 4'h2));
         #1;
         `CHK("done_o early", 1'b0, done_o);
         idle();
         #1;
         `CHK("done_o", 1'b1, done_o);
         wget(4'h7, v);
         `CHK("extract", (32'hb5c3 >> lo[i]) & ((32'h1 << (hi[i] - lo[i] + 1)) - 1),
            v);
      end
      mem[15'h0100] = 16'h1234;
      wset(4'h1, 16'h0200);
      send(fw1(`BCU_OP_EXT_WREG, 4'h7, 4'hf, 4'h8));
      send(fw2(`BCU_AM_POSTINC, 4'h1));
      #1;
      `CHK("mem_raddr_o", 16'h0200, mem_raddr_o);
      idle();
      wget(4'h7, v);
      `CHK("indirect extract", 16'h0012, v);
      wget(4'h1, v);
      `CHK("pointer", 16'h0202, v);
      mem[15'h7fff] = 16'ha5f0;
      send(fw1(`BCU_OP_EXT_FILE, 4'h9, 4'h7, 4'h4));
      send({8'h00, 16'hfffe});
      #1;
      `CHK("mem_raddr_o", 16'hfffe, mem_raddr_o);
      `CHK("mem_page_en_o", 1'b0, mem_page_en_o);
      idle();
      wget(4'h9, v);
      `CHK("file extract", 16'h000f, v);
      $display("test field extract done");
   endtask

   task automatic t_insert();
      logic [15:0] v;
      wset(4'h3, 16'hfff5);
      wset(4'h6, 16'hffff);
      send(fw1(`BCU_OP_INS_WREG, 4'h3, 4'h7, 4'h4));
      send(fw2(`BCU_AM_DIRECT, 4'h6));
      idle();
      wget(4'h6, v);
      `CHK("direct insert", 16'hff5f, v);
      mem[15'h0181] = 16'h0000;
      wset(4'h8, 16'h0300);
      send(fw1(`BCU_OP_INS_WREG, 4'h3, 4'hf, 4'hc));
      send(fw2(`BCU_AM_PREINC, 4'h8));
      #1;
      `CHK("mem_raddr_o", 16'h0302, mem_raddr_o);
      idle();
      #1;
      `CHK("mem_we_o", 1'b1, mem_we_o);
      `CHK("mem_be_o", 2'b11, mem_be_o);
      `CHK("mem_waddr_o", 16'h0302, mem_waddr_o);
      `CHK("mem_wdata_o", 16'h5000, mem_wdata_o);
      wget(4'h8, v);
      `CHK("pointer", 16'h0302, v);
      $display("test field insert done");
   endtask

   task automatic t_refuse_and_reset();
      logic [15:0] v;
      send(24'hffffff);
      idle();
      #1;
      `CHK("illegal_o", 1'b1, illegal_o);
      `CHK("done_o", 1'b0, done_o);
      `CHK("mem_we_o", 1'b0, mem_we_o);
      @(posedge clk_sys_i);
      #1;
      `CHK("illegal_o pulse", 1'b0, illegal_o);
      wset(4'h2, 16'h1234);
      send(fw1(`BCU_OP_EXT_WREG, 4'h7, 4'hf, 4'h0));
      @(posedge clk_sys_i);
      insn_valid_i <= 1'b0;
      rst_n_i <= 1'b0;
      @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      wget(4'h2, v);
      `CHK("wreg after reset", 16'h0000, v);
      mem[15'h0008] = 16'hffff;
      send(clrf(4'h0, 16'h0010));
      idle();
      #1;
      `CHK("done_o", 1'b1, done_o);
      @(posedge clk_sys_i);
      #1;
      `CHK("clear after reset", 16'hfffe, mem[15'h0008]);
      $display("test refusal and reset done");
   endtask

   // ------------------------
   // clock, timeout and main sequence
   // ------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         $display("timeout after %0d cycles", cycles);
         end_sim();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      insn_valid_i = 1'b0;
      insn_i = 24'h000000;
      page_en_i = 1'b1;
      data_read_page_reg_i = 10'h2a5;
      wreg_we_i = 1'b0;
      wreg_waddr_i = 4'h0;
      wreg_wdata_i = 16'h0000;
      wreg_raddr_i = 4'h0;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_clr_file();
      t_clr_wreg();
      t_extract();
      t_insert();
      t_refuse_and_reset();
      end_sim();
   end
endmodule
